// ==== hdl/lcd_seq_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the sequencer
// Assumes a 200 MHz core clock and a 32-bit APB register bus
`ifndef LCD_SEQ_CFG_SVH
`define LCD_SEQ_CFG_SVH

`define CLK_MHZ          200
`define OCP_TIME_US      16000
`define OCP_CYCLES       (`OCP_TIME_US * `CLK_MHZ)

`define NUM_SINKS        6
`define APB_AW           8

`define REG_CTRL         8'h00
`define REG_STATUS       8'h04

`define CTRL_BL_ALLOW    0
`define CTRL_MASK_LSB    8
`define CTRL_RESET       32'h0000_3f01

`define ST_BIAS_LSB      0
`define ST_BL_RUN        4
`define ST_LATCHED       5
`define ST_ALL_OPEN      6
`define ST_OVP_REG       7
`define ST_OPEN_LSB      8
`define ST_SOVP_LSB      16
`define ST_PANEL_RST     24
`define ST_REF_PG        25

`endif

// ==== hdl/lcd_seq_pkg.sv ====
// Types shared by the sequencer modules
// Assumes lcd_seq_cfg.svh is on the include path
package lcd_seq_pkg;

	typedef enum logic [1:0] {
		BIAS_OFF   = 2'b00,
		BIAS_SOFT  = 2'b01,
		BIAS_DELAY = 2'b10,
		BIAS_RUN   = 2'b11
	} bias_state_t;

	typedef logic [5:0] sink_mask_t;

endpackage

// ==== hdl/sync3.sv ====
// Three-stage synchroniser with agreement filter for asynchronous inputs
// Assumes inputs come from pins or analog comparators outside ref_clk
module sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst,
	// Asynchronous in, filtered out
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] nxt_sync_out;

	// A bit changes only once the second and third stages agree
	assign nxt_sync_out = (sync_out & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			s1_ff    <= '0;
			s2_ff    <= '0;
			s3_ff    <= '0;
			sync_out <= '0;
		end else begin
			s1_ff    <= async_in;
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			sync_out <= nxt_sync_out;
		end
	end

endmodule

// ==== hdl/ocp_timer.sv ====
// Persistence timer for boost switch overcurrent
// Assumes oc is already synchronised to ref_clk
module ocp_timer #(
	parameter int CYCLES = 3200000
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Overcurrent while the boost runs
	input  wire logic oc,
	output logic      expired
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_ff;
	logic [CW-1:0] nxt_cnt;
	wire           at_last = (cnt_ff == LAST);

	// Counter restarts whenever the overcurrent clears
	assign nxt_cnt = !oc ? '0 : (at_last ? cnt_ff : cnt_ff + CW'(1));

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt_ff  <= '0;
			expired <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			expired <= oc && at_last;
		end
	end

endmodule

// ==== hdl/lcd_bias_backlight_sequencer.sv ====
// Bias supply and six-string backlight start, stop and fault sequencer
// Assumes comparator results arrive asynchronously; registers over APB
`include "lcd_seq_cfg.svh"
module lcd_bias_backlight_sequencer
	import lcd_seq_pkg::*;
#(
	parameter int OCP_CYCLES = `OCP_CYCLES
) (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// APB slave
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`APB_AW-1:0]     paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Bias section comparators
	input  wire logic                   bias_input_ok,
	input  wire logic                   internal_enable,
	input  wire logic                   ref_in_regulation,
	input  wire logic                   source_supply_pgood,
	input  wire logic                   shaping_delay_pin_done,
	input  wire logic                   voltage_detect_above_hyst,
	input  wire logic                   voltage_detect_below_thr,
	input  wire logic                   flicker_control_in,
	// Backlight section comparators
	input  wire logic                   bl_input_ok,
	input  wire logic                   backlight_output_margin,
	input  wire logic                   bl_enable,
	input  wire logic                   backlight_output_ovp,
	input  wire logic                   sink_below_target,
	input  wire logic                   switch_overcurrent,
	input  wire lcd_seq_pkg::sink_mask_t sink_channel_zero,
	input  wire lcd_seq_pkg::sink_mask_t sink_channel_ovp,
	// Bias section controls
	output logic                        source_supply_boost_en,
	output logic                        ref_en,
	output logic                        common_voltage_buffer_en,
	output logic                        charge_pumps_en,
	output logic                        shaping_delay_pin_chg,
	output logic                        shaped_gate_out,
	output logic                        panel_reset_n,
	output logic                        ref_pgood,
	// Backlight section controls
	output logic                        bl_boost_en,
	output logic                        bl_softstart,
	output logic                        bl_ovp_regulate,
	output lcd_seq_pkg::sink_mask_t     sink_channel_en,
	output lcd_seq_pkg::sink_mask_t     sink_channel_fb
);

	localparam int NI = 14 + 2 * `NUM_SINKS;

	// Synchronised inputs
	logic [NI-1:0] raw_in;
	logic [NI-1:0] syn;
	assign raw_in = {sink_channel_ovp, sink_channel_zero, switch_overcurrent, sink_below_target,
		backlight_output_ovp, bl_enable, backlight_output_margin, bl_input_ok, flicker_control_in,
		voltage_detect_below_thr, voltage_detect_above_hyst, shaping_delay_pin_done, source_supply_pgood,
		ref_in_regulation, internal_enable, bias_input_ok};

	sync3 #(.W(NI)) u_sync (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.async_in (raw_in),
		.sync_out (syn)
	);

	wire        bias_ok_s  = syn[0];
	wire        int_en_s   = syn[1];
	wire        ref_reg_s  = syn[2];
	wire        src_pg_s   = syn[3];
	wire        dly_done_s = syn[4];
	wire        det_hi_s   = syn[5];
	wire        det_lo_s   = syn[6];
	wire        flk_s      = syn[7];
	wire        bat_ok_s   = syn[8];
	wire        margin_s   = syn[9];
	wire        en_s       = syn[10];
	wire        ovp_s      = syn[11];
	wire        below_s    = syn[12];
	wire        oc_s       = syn[13];
	sink_mask_t zero_s;
	sink_mask_t sovp_s;
	assign zero_s = syn[19:14];
	assign sovp_s = syn[25:20];

	// Sequencer held in reset while bias lockout is active
	wire seq_rst = rst || !bias_ok_s;

	// Registers
	logic [31:0] ctrl_ff;
	sink_mask_t  ch_mask;
	wire         bl_allow = ctrl_ff[`CTRL_BL_ALLOW];
	assign ch_mask = ctrl_ff[`CTRL_MASK_LSB +: `NUM_SINKS];

	// Bias sequencer
	bias_state_t state_ff;
	bias_state_t nxt_state;
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			BIAS_OFF:   if (int_en_s) nxt_state = BIAS_SOFT;
			BIAS_SOFT:  if (src_pg_s) nxt_state = BIAS_DELAY;
			BIAS_DELAY: if (dly_done_s) nxt_state = BIAS_RUN;
			BIAS_RUN:   nxt_state = BIAS_RUN;
		endcase
		if (!int_en_s) begin
			nxt_state = BIAS_OFF;
		end
	end

	wire bias_on = (nxt_state != BIAS_OFF);
	wire nxt_ref_pgood = ref_en && ref_reg_s;

	always_ff @(posedge ref_clk) begin
		if (seq_rst) begin
			state_ff                 <= BIAS_OFF;
			source_supply_boost_en   <= 1'b0;
			ref_en                   <= 1'b0;
			common_voltage_buffer_en <= 1'b0;
			charge_pumps_en          <= 1'b0;
			shaping_delay_pin_chg    <= 1'b0;
			ref_pgood                <= 1'b0;
		end else begin
			state_ff                 <= nxt_state;
			source_supply_boost_en   <= bias_on;
			ref_en                   <= bias_on;
			common_voltage_buffer_en <= bias_on;
			charge_pumps_en          <= bias_on;
			shaping_delay_pin_chg    <= (nxt_state == BIAS_DELAY) || (nxt_state == BIAS_RUN);
			ref_pgood                <= nxt_ref_pgood;
		end
	end

	// Reset output and shaped gate stay alive below lockout
	logic nxt_panel_reset_n;
	logic nxt_shaped_gate;
	assign nxt_panel_reset_n = (det_lo_s || !bias_ok_s) ? 1'b0 :
		(det_hi_s ? 1'b1 : panel_reset_n);
	assign nxt_shaped_gate = det_lo_s ? 1'b1 :
		((state_ff == BIAS_RUN && bias_ok_s) ? flk_s : 1'b0);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			panel_reset_n   <= 1'b0;
			shaped_gate_out <= 1'b0;
		end else begin
			panel_reset_n   <= nxt_panel_reset_n;
			shaped_gate_out <= nxt_shaped_gate;
		end
	end

	// Backlight enable and latched shutdown
	logic       latched_ff;
	logic       all_open_ff;
	logic       en_d_ff;
	sink_mask_t open_ff;
	sink_mask_t sovp_ff;
	wire        ocp_expired;
	wire        bl_cond = bat_ok_s && ref_pgood && margin_s && en_s && bl_allow;
	wire        bl_go = bl_cond && !latched_ff && !all_open_ff;
	wire        en_fall = en_d_ff && !en_s;
	wire        latch_clr = !bat_ok_s || en_fall;

	ocp_timer #(.CYCLES(OCP_CYCLES)) u_ocp (
		.ref_clk (ref_clk),
		.rst     (rst),
		.oc      (oc_s && bl_boost_en),
		.expired (ocp_expired)
	);

	// Open and overvoltage channel tracking
	sink_mask_t new_open;
	sink_mask_t nxt_open;
	sink_mask_t nxt_sovp;
	sink_mask_t live;
	assign new_open = (ovp_s && bl_boost_en) ? (zero_s & sink_channel_fb) : '0;
	assign nxt_open = bl_boost_en ? (open_ff | new_open) : '0;
	assign nxt_sovp = bl_boost_en ? (sovp_ff | (sovp_s & sink_channel_en)) : '0;
	assign live = ch_mask & ~nxt_open & ~nxt_sovp;
	wire all_gone = bl_boost_en && (ch_mask != '0) && ((ch_mask & ~nxt_open) == '0);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			latched_ff  <= 1'b0;
			all_open_ff <= 1'b0;
			en_d_ff     <= 1'b0;
		end else begin
			en_d_ff     <= en_s;
			latched_ff  <= ocp_expired || (latched_ff && !latch_clr);
			all_open_ff <= all_gone || (all_open_ff && !latch_clr);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			bl_boost_en     <= 1'b0;
			bl_softstart    <= 1'b0;
			bl_ovp_regulate <= 1'b0;
			open_ff         <= '0;
			sovp_ff         <= '0;
			sink_channel_en <= '0;
			sink_channel_fb <= '0;
		end else begin
			bl_boost_en     <= bl_go && !all_gone && !ocp_expired;
			bl_softstart    <= bl_go && !bl_boost_en;
			bl_ovp_regulate <= bl_go && ovp_s && below_s && (new_open == '0);
			open_ff         <= nxt_open;
			sovp_ff         <= nxt_sovp;
			sink_channel_en <= (bl_go && !all_gone && !ocp_expired) ? (ch_mask & ~nxt_sovp) : '0;
			sink_channel_fb <= (bl_go && !all_gone && !ocp_expired) ? live : '0;
		end
	end

	// APB slave, no wait states
	wire         setup    = psel && !penable;
	wire         access   = psel && penable && pready;
	wire         hit_ctrl = (paddr == `REG_CTRL);
	wire         hit_stat = (paddr == `REG_STATUS);
	logic [31:0] status_w;
	logic [31:0] rd_mux;
	assign status_w = {6'h00, ref_pgood, panel_reset_n, 2'h0, sovp_ff, 2'h0, open_ff,
		bl_ovp_regulate, all_open_ff, latched_ff, bl_boost_en, 2'h0, state_ff};
	assign rd_mux = hit_ctrl ? ctrl_ff : (hit_stat ? status_w : 32'h0000_0000);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ctrl_ff <= `CTRL_RESET;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit_ctrl && !hit_stat;
			prdata  <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
			if (access && pwrite && hit_ctrl) begin
				ctrl_ff <= pwdata;
			end
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	bl_stop_a: assert property (!bl_cond |=> !bl_boost_en && sink_channel_en == '0)
		else $error("backlight ran with an enable condition false");
	bl_start_a: assert property ($rose(bl_boost_en) |-> bl_softstart && $past(bl_cond))
		else $error("backlight started without soft-start or conditions");
	bias_lock_a: assert property (!bias_ok_s |=> !source_supply_boost_en && !ref_en ##1 !ref_pgood)
		else $error("bias block on under lockout");
	ref_drop_a: assert property (!bias_ok_s |=> ##1 !bl_boost_en)
		else $error("backlight survived bias lockout");
	gate_pdown_a: assert property (det_lo_s |=> shaped_gate_out && !panel_reset_n)
		else $error("power-down discharge not driven");
	gate_low_a: assert property (state_ff != BIAS_RUN && !det_lo_s |=> !shaped_gate_out)
		else $error("shaped gate high during power-up");
	gate_follow_a: assert property (state_ff == BIAS_RUN && bias_ok_s && !det_lo_s
		|=> shaped_gate_out == $past(flk_s))
		else $error("shaped gate not following flicker input");
	delay_chg_a: assert property (state_ff == BIAS_SOFT && src_pg_s && int_en_s && bias_ok_s
		|=> shaping_delay_pin_chg)
		else $error("shaping delay charge not started");
	sink_ovp_a: assert property ((sovp_s & sink_channel_en) != '0 |=> ((sink_channel_en & $past(sovp_s)) == '0))
		else $error("overvoltage sink left on");
	open_drop_a: assert property (new_open != '0 |=> (sink_channel_fb & $past(new_open)) == '0)
		else $error("open string kept in feedback");
	reset_rel_a: assert property (det_hi_s && !det_lo_s && bias_ok_s |=> panel_reset_n)
		else $error("reset output not released");
	ocp_latch_a: assert property (ocp_expired |=> latched_ff && !bl_boost_en)
		else $error("overcurrent did not latch off");

	bl_run_c: cover property ($rose(bl_boost_en));
	open_c: cover property (new_open != '0 ##1 bl_boost_en);
	gate_run_c: cover property (state_ff == BIAS_RUN ##1 shaped_gate_out);
	apb_wr_c: cover property (access && pwrite && hit_ctrl);

endmodule

// ==== verif/lcd_far_side_model.sv ====
// Far-side analog model: regulation and power-good comparators
// Assumes the enables come from the sequencer, registered on ref_clk
module lcd_far_side_model #(
	parameter int LAT = 16
) (
	// Clock
	input  wire logic ref_clk,
	// Enables from the sequencer
	input  wire logic ref_en,
	input  wire logic source_supply_boost_en,
	input  wire logic shaping_delay_pin_chg,
	// Comparator results
	output logic      ref_in_regulation,
	output logic      source_supply_pgood,
	output logic      shaping_delay_pin_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [LAT-1:0] ramp_ref;
	logic [LAT-1:0] ramp_src;
	logic [LAT-1:0] ramp_dly;
	// Each output ramps LAT cycles after its enable, drops soon after it
	always_ff @(posedge ref_clk) begin
		ramp_ref <= {ramp_ref[LAT-2:0], ref_en};
		ramp_src <= {ramp_src[LAT-2:0], source_supply_boost_en};
		ramp_dly <= {ramp_dly[LAT-2:0], shaping_delay_pin_chg};
	end
	assign ref_in_regulation      = &ramp_ref;
	assign source_supply_pgood    = &ramp_src;
	assign shaping_delay_pin_done = &ramp_dly;
endmodule

// ==== verif/lcd_bias_backlight_sequencer_tb.sv ====
// Self-checking bench of the bias and backlight sequencer
// Assumes the far-side model answers the bias enables
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(c) begin k = 0; while (!(c) && k < 200) begin @(posedge ref_clk); k++; end \
	if (!(c)) n_mismatch++; end
module lcd_bias_backlight_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lcd_seq_pkg::*;
	logic ref_clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic bias_input_ok, internal_enable, ref_in_regulation, source_supply_pgood, shaping_delay_pin_done;
	logic voltage_detect_above_hyst, voltage_detect_below_thr, flicker_control_in, bl_input_ok;
	logic backlight_output_margin;
	logic bl_enable, backlight_output_ovp, sink_below_target, switch_overcurrent;
	logic source_supply_boost_en, ref_en, common_voltage_buffer_en, charge_pumps_en, shaping_delay_pin_chg;
	logic shaped_gate_out, panel_reset_n, ref_pgood, bl_boost_en, bl_softstart, bl_ovp_regulate;
	sink_mask_t sink_channel_zero, sink_channel_ovp, sink_channel_en, sink_channel_fb;
	logic [32:0] exp_q[$];
	logic [32:0] exp_v;
	logic f;
	int n_mismatch, n_checks, k;

	lcd_bias_backlight_sequencer #(.OCP_CYCLES(20)) u_dut (.ref_clk, .rst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .bias_input_ok, .internal_enable, .ref_in_regulation,
		.source_supply_pgood, .shaping_delay_pin_done, .voltage_detect_above_hyst, .voltage_detect_below_thr,
		.flicker_control_in, .bl_input_ok, .backlight_output_margin, .bl_enable, .backlight_output_ovp,
		.sink_below_target,
		.switch_overcurrent, .sink_channel_zero, .sink_channel_ovp, .source_supply_boost_en, .ref_en,
		.common_voltage_buffer_en, .charge_pumps_en, .shaping_delay_pin_chg, .shaped_gate_out,
		.panel_reset_n, .ref_pgood, .bl_boost_en, .bl_softstart, .bl_ovp_regulate, .sink_channel_en,
		.sink_channel_fb);
	lcd_far_side_model u_far (.ref_clk, .ref_en, .source_supply_boost_en, .shaping_delay_pin_chg,
		.ref_in_regulation, .source_supply_pgood, .shaping_delay_pin_done);

	initial begin
		ref_clk = 0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic settle();
		repeat (8) @(posedge ref_clk);
	endtask

	// One APB transfer; reads note their expected {pslverr, prdata}
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		if (!w) exp_q.push_back(e);
		@(posedge ref_clk);
		`WAITF(pready === 1)
		psel <= 0;
		penable <= 0;
		@(posedge ref_clk);
	endtask

	task automatic toggle_en();
		bl_enable <= 0;
		settle();
		bl_enable <= 1;
		settle();
	endtask

	// Read checker takes the oldest note at each completed read
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1 && !pwrite) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("BAD t=%0t got=%h exp=%h", $time, prdata, 32'h0);
			end else begin
				exp_v = exp_q.pop_front();
				`CHK({pslverr, prdata}, exp_v)
			end
		end
	end

	task automatic results();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		results();
	end

	initial begin
		{rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{bias_input_ok, internal_enable, voltage_detect_above_hyst, voltage_detect_below_thr, flicker_control_in} = 5'h0;
		{bl_input_ok, backlight_output_margin, bl_enable, backlight_output_ovp} = 4'h0;
		{sink_below_target, switch_overcurrent, sink_channel_zero, sink_channel_ovp} = 14'h0;
		f = 1'($urandom(5630));
		repeat (12) @(posedge ref_clk);
		rst <= 0;
		apb(0, 8'h00, 0, 33'h0_0000_3f01);
		apb(0, 8'h04, 0, 33'h0);
		apb(0, 8'h08, 0, 33'h1_0000_0000);
		apb(1, 8'h00, 32'h0000_2d01, 0);
		apb(0, 8'h00, 0, 33'h0_0000_2d01);
		bl_input_ok <= 1;
		internal_enable <= 1;
		flicker_control_in <= 1;
		settle();
		`CHK(source_supply_boost_en, 1'b0)
		`CHK(panel_reset_n, 1'b0)
		bias_input_ok <= 1;
		settle();
		`CHK({source_supply_boost_en, ref_en, common_voltage_buffer_en, charge_pumps_en}, 4'hf)
		`CHK(shaping_delay_pin_chg, 1'b0)
		`WAITF(shaping_delay_pin_chg === 1)
		`CHK(shaping_delay_pin_chg, 1'b1)
		`CHK(ref_pgood, 1'b1)
		`CHK(shaped_gate_out, 1'b0)
		`WAITF(shaped_gate_out === 1)
		`CHK(shaped_gate_out, 1'b1)
		repeat (4) begin
			f = 1'($urandom);
			flicker_control_in <= f;
			settle();
			`CHK(shaped_gate_out, f)
		end
		voltage_detect_above_hyst <= 1;
		settle();
		`CHK(panel_reset_n, 1'b1)
		apb(0, 8'h04, 0, 33'h0_0300_0003);
		voltage_detect_above_hyst <= 0;
		backlight_output_margin <= 1;
		bl_enable <= 1;
		`WAITF(bl_boost_en === 1)
		`CHK(bl_softstart, 1'b1)
		`CHK({sink_channel_en, sink_channel_fb}, {6'h2d, 6'h2d})
		@(posedge ref_clk);
		`CHK(bl_softstart, 1'b0)
		backlight_output_ovp <= 1;
		sink_channel_zero <= 6'h01;
		settle();
		`CHK({sink_channel_en, sink_channel_fb}, {6'h2d, 6'h2c})
		`CHK(bl_boost_en, 1'b1)
		sink_channel_zero <= 0;
		sink_below_target <= 1;
		settle();
		`CHK({bl_ovp_regulate, bl_boost_en}, 2'b11)
		{backlight_output_ovp, sink_below_target} <= 2'b00;
		sink_channel_ovp <= 6'h04;
		settle();
		`CHK({sink_channel_en, sink_channel_fb}, {6'h29, 6'h28})
		sink_channel_ovp <= 0;
		for (int i = 0; i < 3; i++) begin
			{bl_input_ok, backlight_output_margin, bl_enable} <= 3'b111 ^ (3'b001 << i);
			settle();
			`CHK({bl_boost_en, sink_channel_en}, 7'h0)
			{bl_input_ok, backlight_output_margin, bl_enable} <= 3'b111;
			settle();
			`CHK({bl_boost_en, sink_channel_en}, {1'b1, 6'h2d})
		end
		apb(1, 8'h00, 32'h0000_2d00, 0);
		settle();
		`CHK({bl_boost_en, sink_channel_en}, 7'h0)
		apb(1, 8'h00, 32'h0000_2d01, 0);
		settle();
		`CHK({bl_boost_en, sink_channel_en}, {1'b1, 6'h2d})
		backlight_output_ovp <= 1;
		sink_channel_zero <= 6'h2d;
		settle();
		`CHK(bl_boost_en, 1'b0)
		{backlight_output_ovp, sink_channel_zero} <= 7'h0;
		toggle_en();
		`CHK(bl_boost_en, 1'b1)
		switch_overcurrent <= 1;
		repeat (40) @(posedge ref_clk);
		switch_overcurrent <= 0;
		settle();
		`CHK(bl_boost_en, 1'b0)
		toggle_en();
		`CHK(bl_boost_en, 1'b1)
		voltage_detect_below_thr <= 1;
		settle();
		`CHK({panel_reset_n, shaped_gate_out}, 2'b01)
		bias_input_ok <= 0;
		settle();
		settle();
		`CHK({source_supply_boost_en, ref_en, common_voltage_buffer_en, charge_pumps_en}, 4'h0)
		`CHK({ref_pgood, bl_boost_en, shaped_gate_out}, 3'b001)
		apb(0, 8'h04, 0, 33'h0_0000_0000);
		results();
	end
endmodule
